// ==== verilog/sfps_pkg.sv ====
// Shared constants, opcodes and helpers for the serial flash program block
`default_nettype none
package sfps_pkg;
	// Opcodes
	localparam logic [7:0] OP_WR_BUF1   = 8'h84;
	localparam logic [7:0] OP_WR_BUF2   = 8'h87;
	localparam logic [7:0] OP_EP_BUF1   = 8'h83;
	localparam logic [7:0] OP_EP_BUF2   = 8'h86;
	localparam logic [7:0] OP_PO_BUF1   = 8'h88;
	localparam logic [7:0] OP_PO_BUF2   = 8'h89;
	localparam logic [7:0] OP_MMP_BUF1  = 8'h82;
	localparam logic [7:0] OP_MMP_BUF2  = 8'h85;
	localparam logic [7:0] OP_APR_BUF1  = 8'h58;
	localparam logic [7:0] OP_APR_BUF2  = 8'h59;
	localparam logic [7:0] OP_CMP_BUF1  = 8'h60;
	localparam logic [7:0] OP_CMP_BUF2  = 8'h61;
	localparam logic [7:0] OP_STATUS    = 8'h57;
	// Frame layout
	localparam int         OP_BITS      = 8;
	localparam int         CMD_BITS     = 32;
	localparam int         BADDR_W      = 9;
	localparam int         PAGE_W       = 12;
	localparam int         PAGE_LSB     = 9;
	localparam int         RSVD_LSB     = 21;
	localparam int         BUF_BYTES    = 264;
	localparam int         PAGES        = 4096;
	// Status byte
	localparam int         ST_READY_BIT = 7;
	localparam int         ST_COMP_BIT  = 6;
	// Density code value is arbitrary
	localparam logic [2:0] DENSITY_CODE = 3'h5;
	localparam logic [2:0] ST_RSVD      = 3'h0;
	localparam logic [7:0] ERASED_BYTE  = 8'hff;
	// Timing
	localparam int         CLK_PERIOD_NS          = 100;
	localparam int         erase_program_time_max = 20000;
	localparam int         program_only_time_max  = 14000;
	localparam int         xfr_time_max           = 150;
	localparam int         EP_CYCLES  = erase_program_time_max * 1000
		/ CLK_PERIOD_NS;
	localparam int         PO_CYCLES  = program_only_time_max * 1000
		/ CLK_PERIOD_NS;
	localparam int         XFR_CYCLES = xfr_time_max * 1000 / CLK_PERIOD_NS;
	localparam int         TMR_W      = 18;
	localparam int         CS_HIGH_NS = 250;
	localparam int         CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int         SCK_HALF   = 4;

	typedef enum {K_EP, K_PO, K_APR, K_CMP} sfps_kind_e;

	function automatic logic sfps_is_array(input logic [7:0] op);
		return !(op == OP_WR_BUF1 || op == OP_WR_BUF2 || op == OP_STATUS);
	endfunction

	function automatic logic sfps_buf2(input logic [7:0] op);
		return op == OP_WR_BUF2 || op == OP_EP_BUF2 || op == OP_PO_BUF2
			|| op == OP_MMP_BUF2 || op == OP_APR_BUF2 || op == OP_CMP_BUF2;
	endfunction
endpackage
`default_nettype wire

// ==== verilog/sfps_if.sv ====
// Serial link between host and flash device, with pin resolution
`default_nettype none
interface sfps_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so_o;
	logic so_oe;
	logic rb_o;
	logic rb_oe;
	logic so;
	logic rdy;

	// Released lines float high
	assign so  = so_oe ? so_o : 1'b1;
	assign rdy = rb_oe ? rb_o : 1'b1;

	modport dev(input cs_n, input sck, input si,
		output so_o, output so_oe, output rb_o, output rb_oe);
	modport host(output cs_n, output sck, output si,
		input so, input rdy);
endinterface
`default_nettype wire

// ==== verilog/sfps_dev.sv ====
// Flash device end: serial command decode, buffers, self-timed array ops
//
// Overview of operation
// - 84H/87H, 15 ignored bits, buffer address
// - Data bytes fill buffer, wrap, until deselect
// - 83H/86H, reserved bits, page, ignored bits
// - Deselect starts erase then program, busy
// - 88H/89H program only, busy meanwhile
// - Host programs-only erased pages
// - 82H/85H page then buffer address, data
// - Deselect erases then programs loaded buffer
// - 58H/59H rewrite page from itself, busy; code only holds busy for erase-program time
// - 57H shifts status out, bit 7 first
// - Status byte repeats with fresh values
// - Bit 7 one when ready, zero busy
// - Halted clock keeps live ready on output
// - Only ten array opcodes set busy
// - Bit 6 holds last compare mismatch
// - Bits 5..3 fixed density code
// - Low three status bits reserved
// - Host starts no array op while busy
// - Buffer and status access allowed while busy
// - Frame starts at select, MSB first
// - Ready pin pulled low while busy
// - Host sends reserved bits as zero
`default_nettype none
module sfps_dev
	import sfps_pkg::*;
#(
	parameter int N_PAGES = sfps_pkg::PAGES,
	parameter int EP_CYC  = sfps_pkg::EP_CYCLES,
	parameter int PO_CYC  = sfps_pkg::PO_CYCLES,
	parameter int XFR_CYC = sfps_pkg::XFR_CYCLES
) (
	// Internal timer clock and reset
	input  wire logic CLK,
	input  wire logic RST,
	// Serial link
	sfps_if.dev       LINK,
	// Device state
	output logic      BUSY
);
	import sfps_pkg::*;

	localparam int MEM_AW = $clog2(N_PAGES * BUF_BYTES);

	typedef enum {S_IDLE, S_ERASE, S_PROG, S_WAIT} sfps_state_e;

	// Storage
	logic [7:0]         buf_mem [2][BUF_BYTES];
	logic [7:0]         page_mem [N_PAGES * BUF_BYTES];

	// Link domain
	logic [5:0]         cnt_r;
	logic [CMD_BITS-1:0] shift_r;
	logic [7:0]         op_r;
	logic [BADDR_W-1:0] baddr_r;
	logic [2:0]         dbit_r;
	logic [6:0]         dbyte_r;
	logic [7:0]         arr_op_r;
	logic [PAGE_W-1:0]  arr_page_r;
	logic               arm_tgl_r;
	logic               rdy_s1;
	logic               rdy_s2;
	logic               cmp_s1;
	logic               cmp_s2;
	logic               so_r;
	logic               so_oe_r;
	logic [2:0]         st_bit_r;
	logic [7:0]         st_byte;
	logic [CMD_BITS-1:0] word_in;
	logic               arr_cmd;

	// Timer domain
	logic               cs_s1;
	logic               cs_s2;
	logic               cs_s3;
	logic               arm_s1;
	logic               arm_s2;
	logic               arm_seen_r;
	sfps_state_e        state_r;
	sfps_kind_e         kind_r;
	logic               busy_r;
	logic               comp_r;
	logic               mism_r;
	logic               sel_r;
	logic [PAGE_W-1:0]  page_r;
	logic [BADDR_W-1:0] idx_r;
	logic [TMR_W-1:0]   tmr_r;
	logic [TMR_W-1:0]   limit_r;
	logic               start;
	logic [MEM_AW-1:0]  maddr;

	assign word_in = {shift_r[CMD_BITS-2:0], LINK.si};

	// Only listed array opcodes launch; reads and transfers are not built
	assign arr_cmd = op_r inside {OP_EP_BUF1, OP_EP_BUF2, OP_PO_BUF1,
		OP_PO_BUF2, OP_MMP_BUF1, OP_MMP_BUF2, OP_APR_BUF1, OP_APR_BUF2,
		OP_CMP_BUF1, OP_CMP_BUF2};

	// Bit position within the frame, cleared while deselected
	always_ff @(posedge LINK.sck or posedge LINK.cs_n) begin
		if (LINK.cs_n)
			cnt_r <= '0;
		else if (cnt_r != 6'(CMD_BITS))
			cnt_r <= cnt_r + 6'h01;
	end

	always_ff @(posedge LINK.sck) begin
		shift_r <= word_in;
		if (cnt_r == 6'(OP_BITS - 1))
			op_r <= word_in[7:0];
		rdy_s1 <= ~busy_r;
		rdy_s2 <= rdy_s1;
		cmp_s1 <= comp_r;
		cmp_s2 <= cmp_s1;
	end

	// Buffer loading; free while an array op runs
	always_ff @(posedge LINK.sck) begin
		if (cnt_r == 6'(CMD_BITS - 1))
			baddr_r <= word_in[BADDR_W-1:0];
		else if (cnt_r == 6'(CMD_BITS) && dbit_r == 3'h7
			&& (op_r == OP_WR_BUF1 || op_r == OP_WR_BUF2
			|| op_r == OP_MMP_BUF1 || op_r == OP_MMP_BUF2)) begin
			buf_mem[sfps_buf2(op_r)][baddr_r] <= {dbyte_r, LINK.si};
			if (baddr_r == BADDR_W'(BUF_BYTES - 1))
				baddr_r <= '0;
			else
				baddr_r <= baddr_r + 9'h001;
		end
	end

	always_ff @(posedge LINK.sck or posedge LINK.cs_n) begin
		if (LINK.cs_n) begin
			dbit_r  <= '0;
			dbyte_r <= '0;
		end else if (cnt_r == 6'(CMD_BITS)) begin
			dbit_r  <= dbit_r + 3'h1;
			dbyte_r <= {dbyte_r[5:0], LINK.si};
		end
	end

	// Array command hand-off, toggled once its address is complete
	always_ff @(posedge LINK.sck or posedge RST) begin
		if (RST) begin
			arm_tgl_r  <= 1'b0;
			arr_op_r   <= '0;
			arr_page_r <= '0;
		end else if (cnt_r == 6'(CMD_BITS - 1) && arr_cmd) begin
			arm_tgl_r  <= ~arm_tgl_r;
			arr_op_r   <= op_r;
			arr_page_r <= word_in[PAGE_LSB +: PAGE_W];
		end
	end

	// Status byte, sampled live on every bit
	assign st_byte = {rdy_s2, cmp_s2, DENSITY_CODE, ST_RSVD};

	always_ff @(negedge LINK.sck or posedge LINK.cs_n) begin
		if (LINK.cs_n) begin
			so_oe_r  <= 1'b0;
			so_r     <= 1'b0;
			st_bit_r <= 3'(ST_READY_BIT);
		end else if (cnt_r >= 6'(OP_BITS) && op_r == OP_STATUS) begin
			so_oe_r  <= 1'b1;
			so_r     <= st_byte[st_bit_r];
			st_bit_r <= st_bit_r - 3'h1;
		end
	end

	// While bit 7 stands, show the timer domain's ready directly
	assign LINK.so_o  = (st_bit_r == 3'(ST_READY_BIT - 1)) ? ~busy_r : so_r;
	assign LINK.so_oe = so_oe_r;
	assign LINK.rb_o  = 1'b0;
	assign LINK.rb_oe = busy_r;

	// Deselect and hand-off synchronisers
	always_ff @(posedge CLK) begin
		if (RST) begin
			cs_s1  <= 1'b1;
			cs_s2  <= 1'b1;
			cs_s3  <= 1'b1;
			arm_s1 <= 1'b0;
			arm_s2 <= 1'b0;
		end else begin
			cs_s1  <= LINK.cs_n;
			cs_s2  <= cs_s1;
			cs_s3  <= cs_s2;
			arm_s1 <= arm_tgl_r;
			arm_s2 <= arm_s1;
		end
	end

	assign start = cs_s2 && !cs_s3 && (arm_s2 != arm_seen_r)
		&& state_r == S_IDLE;
	assign maddr = MEM_AW'(page_r * BUF_BYTES) + MEM_AW'(idx_r);

	// Self-timed operation sequencer
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r    <= S_IDLE;
			kind_r     <= K_EP;
			busy_r     <= 1'b0;
			comp_r     <= 1'b0;
			mism_r     <= 1'b0;
			sel_r      <= 1'b0;
			page_r     <= '0;
			idx_r      <= '0;
			tmr_r      <= '0;
			limit_r    <= '0;
			arm_seen_r <= 1'b0;
		end else begin
			if (cs_s2 && !cs_s3)
				arm_seen_r <= arm_s2;
			if (state_r != S_IDLE)
				tmr_r <= tmr_r + 18'h00001;
			unique case (state_r)
			S_IDLE: begin
				if (start) begin
					busy_r <= 1'b1;
					tmr_r  <= '0;
					idx_r  <= '0;
					mism_r <= 1'b0;
					sel_r  <= sfps_buf2(arr_op_r);
					page_r <= arr_page_r;
					if (arr_op_r == OP_PO_BUF1 || arr_op_r == OP_PO_BUF2) begin
						kind_r  <= K_PO;
						limit_r <= TMR_W'(PO_CYC);
						state_r <= S_PROG;
					end else if (arr_op_r == OP_CMP_BUF1
						|| arr_op_r == OP_CMP_BUF2) begin
						kind_r  <= K_CMP;
						limit_r <= TMR_W'(XFR_CYC);
						state_r <= S_PROG;
					end else if (arr_op_r == OP_APR_BUF1
						|| arr_op_r == OP_APR_BUF2) begin
						kind_r  <= K_APR;
						limit_r <= TMR_W'(EP_CYC);
						state_r <= S_WAIT;
					end else begin
						kind_r  <= K_EP;
						limit_r <= TMR_W'(EP_CYC);
						state_r <= S_ERASE;
					end
				end
			end
			S_ERASE: begin
				page_mem[maddr] <= ERASED_BYTE;
				if (idx_r == BADDR_W'(BUF_BYTES - 1)) begin
					idx_r   <= '0;
					state_r <= S_PROG;
				end else
					idx_r <= idx_r + 9'h001;
			end
			S_PROG: begin
				if (kind_r == K_CMP) begin
					if (page_mem[maddr] != buf_mem[sel_r][idx_r])
						mism_r <= 1'b1;
				end else
					page_mem[maddr] <= page_mem[maddr]
						& buf_mem[sel_r][idx_r];
				if (idx_r == BADDR_W'(BUF_BYTES - 1))
					state_r <= S_WAIT;
				else
					idx_r <= idx_r + 9'h001;
			end
			S_WAIT: begin
				if (kind_r == K_CMP)
					comp_r <= mism_r;
				if (tmr_r >= limit_r - 18'h00001) begin
					busy_r  <= 1'b0;
					state_r <= S_IDLE;
				end
			end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST)
			BUSY <= 1'b0;
		else
			BUSY <= busy_r;
	end
endmodule
`default_nettype wire

// ==== verilog/sfps_host.sv ====
// Host end: frames commands onto the serial link, divides its clock
`default_nettype none
module sfps_host
	import sfps_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// Serial link
	sfps_if.host             LINK,
	// Command request
	input  wire logic        REQ_VALID,
	output logic             REQ_READY,
	input  wire logic [7:0]  REQ_OP,
	input  wire logic [23:0] REQ_ADDR,
	input  wire logic [8:0]  REQ_LEN,
	// Write data
	input  wire logic [7:0]  WR_DATA,
	output logic             WR_TAKE,
	// Status answer
	output logic             RSP_VALID,
	output logic [7:0]       RSP_STATUS,
	output logic             DEV_BUSY
);
	import sfps_pkg::*;

	typedef enum {H_IDLE, H_SHIFT, H_GAP} sfps_hstate_e;

	// Cycles until the synced busy pin can show a just-launched op
	localparam logic [2:0] BUSY_LAG = 3'h7;

	sfps_hstate_e        state_r;
	logic [2:0]          ph_r;
	logic                sck_r;
	logic                cs_n_r;
	logic                si_r;
	logic [CMD_BITS-1:0] tx_r;
	logic [12:0]         sent_r;
	logic [12:0]         total_r;
	logic [7:0]          rx_r;
	logic                stat_r;
	logic [1:0]          gap_r;
	logic                so_s1;
	logic                so_s2;
	logic                rdy_s1;
	logic                rdy_s2;
	logic                tick;
	logic                arr_r;
	logic [2:0]          hold_r;

	assign LINK.cs_n = cs_n_r;
	assign LINK.sck  = sck_r;
	assign LINK.si   = si_r;
	assign tick      = ph_r == 3'(SCK_HALF - 1);

	// Keep array ops off until the busy pin has had time to show
	always_ff @(posedge CLK) begin
		if (RST)
			hold_r <= '0;
		else if (state_r == H_SHIFT && tick && !sck_r && sent_r == total_r
			&& arr_r)
			hold_r <= BUSY_LAG;
		else if (hold_r != 3'h0)
			hold_r <= hold_r - 3'h1;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			so_s1    <= 1'b1;
			so_s2    <= 1'b1;
			rdy_s1   <= 1'b1;
			rdy_s2   <= 1'b1;
			DEV_BUSY <= 1'b0;
		end else begin
			so_s1    <= LINK.so;
			so_s2    <= so_s1;
			rdy_s1   <= LINK.rdy;
			rdy_s2   <= rdy_s1;
			DEV_BUSY <= ~rdy_s2;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r    <= H_IDLE;
			ph_r       <= '0;
			sck_r      <= 1'b0;
			cs_n_r     <= 1'b1;
			si_r       <= 1'b0;
			tx_r       <= '0;
			sent_r     <= '0;
			total_r    <= '0;
			rx_r       <= '0;
			stat_r     <= 1'b0;
			arr_r      <= 1'b0;
			gap_r      <= '0;
			REQ_READY  <= 1'b1;
			WR_TAKE    <= 1'b0;
			RSP_VALID  <= 1'b0;
			RSP_STATUS <= '0;
		end else begin
			WR_TAKE   <= 1'b0;
			RSP_VALID <= 1'b0;
			unique case (state_r)
			H_IDLE: begin
				// Array ops wait for the device to go ready
				if (REQ_VALID && REQ_READY
					&& !(sfps_is_array(REQ_OP)
					&& (DEV_BUSY || hold_r != 3'h0))) begin
					REQ_READY <= 1'b0;
					cs_n_r    <= 1'b0;
					ph_r      <= '0;
					sent_r    <= '0;
					stat_r    <= REQ_OP == OP_STATUS;
					arr_r     <= sfps_is_array(REQ_OP);
					tx_r      <= {REQ_OP, 3'h0, REQ_ADDR[RSVD_LSB-1:0]};
					si_r      <= REQ_OP[7];
					// Status reads run REQ_LEN extra repeats of the byte
					total_r   <= {1'b0, REQ_LEN, 3'h0} + ((REQ_OP == OP_STATUS)
						? 13'(2 * OP_BITS) : 13'(CMD_BITS));
					state_r   <= H_SHIFT;
				end
			end
			H_SHIFT: begin
				ph_r <= tick ? 3'h0 : ph_r + 3'h1;
				if (tick && !sck_r) begin
					if (sent_r == total_r) begin
						cs_n_r  <= 1'b1;
						gap_r   <= '0;
						state_r <= H_GAP;
					end else begin
						sck_r  <= 1'b1;
						rx_r   <= {rx_r[6:0], so_s2};
						sent_r <= sent_r + 13'h0001;
					end
				end else if (tick) begin
					sck_r <= 1'b0;
					if (!stat_r && sent_r >= 13'(CMD_BITS)
						&& sent_r[2:0] == 3'h0) begin
						tx_r    <= {WR_DATA, 24'h0};
						si_r    <= WR_DATA[7];
						WR_TAKE <= 1'b1;
					end else begin
						tx_r <= {tx_r[CMD_BITS-2:0], 1'b0};
						si_r <= tx_r[CMD_BITS-2];
					end
				end
			end
			H_GAP: begin
				if (gap_r == 2'(CS_HIGH_CYC - 1)) begin
					RSP_VALID  <= stat_r;
					RSP_STATUS <= rx_r;
					REQ_READY  <= 1'b1;
					state_r    <= H_IDLE;
				end else
					gap_r <= gap_r + 2'h1;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== dv/sfps_assertions.sv ====
// Concurrent checks on the serial link between host and device ends
`default_nettype none
module sfps_assertions
	import sfps_pkg::*;
#(
	parameter int EP_CYC  = 800,
	parameter int PO_CYC  = 700,
	parameter int XFR_CYC = 600
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Link lines
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so_o,
	input wire logic so_oe,
	input wire logic rb_o,
	input wire logic rb_oe,
	input wire logic so,
	input wire logic rdy
);
	logic [7:0]  op_r;
	logic [11:0] cnt_r;
	logic        sck_r;
	logic [19:0] bsy_r;
	logic [19:0] lim_r;
	logic [7:0]  qt_r;
	logic        rise;
	logic        arr;
	assign rise = !cs_n && sck && !sck_r;
	assign arr  = !(op_r inside {OP_WR_BUF1, OP_WR_BUF2, OP_STATUS});
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	always_ff @(posedge CLK) sck_r <= sck;
	always_ff @(posedge CLK) begin
		if (cs_n) cnt_r <= 12'h0;
		else if (rise) cnt_r <= cnt_r + 12'h1;
	end
	always_ff @(posedge CLK) if (rise && cnt_r < 12'h8) op_r <= {op_r[6:0], si};
	always_ff @(posedge CLK) bsy_r <= rb_oe ? bsy_r + 20'h1 : 20'h0;
	// Cycles since ready pin last moved
	always_ff @(posedge CLK) begin
		if (RST) qt_r <= 8'hff;
		else if ($changed(rb_oe)) qt_r <= 8'h0;
		else if (qt_r != 8'hff) qt_r <= qt_r + 8'h1;
	end
	// Expected busy length of the op just launched
	always_ff @(posedge CLK) begin
		if (cs_n && cnt_r >= 12'd32 && arr && !rb_oe) begin
			if (op_r inside {OP_PO_BUF1, OP_PO_BUF2}) lim_r <= 20'(PO_CYC);
			else if (op_r inside {OP_CMP_BUF1, OP_CMP_BUF2}) lim_r <= 20'(XFR_CYC);
			else lim_r <= 20'(EP_CYC);
		end
	end
	property p_rb_drive; rb_oe |-> !rb_o; endproperty
	a_rb_drive: assert property (p_rb_drive)
		else $error("ready pin enabled but not low");
	property p_launch;
		$rose(cs_n) && cnt_r >= 12'd32 && arr && !rb_oe |-> ##[1:8] rb_oe;
	endproperty
	a_launch: assert property (p_launch)
		else $error("array op did not raise busy");
	property p_len;
		$fell(rb_oe) |-> bsy_r + 20'd4 >= lim_r && bsy_r <= lim_r + 20'd4;
	endproperty
	a_len: assert property (p_len)
		else $error("busy length off its limit");
	property p_quiet; $rose(cs_n) && !arr && !rb_oe |-> !rb_oe [*8]; endproperty
	a_quiet: assert property (p_quiet)
		else $error("buffer or status frame raised busy");
	property p_bit7;
		rise && op_r == OP_STATUS && cnt_r >= 12'd8 && cnt_r[2:0] == 3'h0
			&& qt_r > 8'd100 |-> so == rdy;
	endproperty
	a_bit7: assert property (p_bit7)
		else $error("status top bit not ready");
	property p_density;
		rise && op_r == OP_STATUS && cnt_r >= 12'd8 && cnt_r[2:0] inside {2, 3, 4}
			|-> so == DENSITY_CODE[3'd4 - cnt_r[2:0]];
	endproperty
	a_density: assert property (p_density)
		else $error("density bits wrong");
	property p_rsvd;
		rise && cnt_r >= 12'd8 && cnt_r < 12'd11 && op_r != OP_STATUS |-> !si;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved address bit not zero");
	property p_gap; $rose(cs_n) |-> cs_n [*3]; endproperty
	a_gap: assert property (p_gap)
		else $error("select high time too short");
	property p_so_en;
		so_oe |-> !cs_n && op_r == OP_STATUS && cnt_r >= 12'd8;
	endproperty
	a_so_en: assert property (p_so_en)
		else $error("output driven outside a status read");
endmodule
`default_nettype wire

// ==== dv/serial_flash_program_status_tb_top.sv ====
// Bench joining host and device ends over the serial link
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
	err_count++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module serial_flash_program_status_tb_top
	import sfps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        CLK;
	logic        RST;
	logic        req_valid;
	logic        req_ready;
	logic [7:0]  req_op;
	logic [23:0] req_addr;
	logic [8:0]  req_len;
	logic [7:0]  wr_data;
	logic        wr_take;
	logic        rsp_valid;
	logic [7:0]  rsp_status;
	logic        dev_busy;
	logic        busy;
	logic [7:0]  wbuf [264];
	logic [7:0]  b1 [264];
	logic [7:0]  b2 [264];
	int          wr_idx;
	int          err_count;
	int          checked;
	int          n_stat;
	int          n_rsp = 0;
	localparam logic [7:0]  T_OP [5] = '{OP_PO_BUF1, OP_EP_BUF2, OP_PO_BUF2,
		OP_APR_BUF1, OP_APR_BUF2};
	localparam logic [7:0]  T_CMP [5] = '{OP_CMP_BUF1, OP_CMP_BUF2,
		OP_CMP_BUF2, OP_CMP_BUF1, OP_CMP_BUF2};
	localparam logic [11:0] T_PG [5] = '{12'h3, 12'h2, 12'h5, 12'h3, 12'h2};
	sfps_if lnk ();
	sfps_host i_sfps_host (.CLK(CLK), .RST(RST), .LINK(lnk),
		.REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_OP(req_op),
		.REQ_ADDR(req_addr), .REQ_LEN(req_len), .WR_DATA(wr_data),
		.WR_TAKE(wr_take), .RSP_VALID(rsp_valid), .RSP_STATUS(rsp_status),
		.DEV_BUSY(dev_busy));
	sfps_dev #(.N_PAGES(16), .EP_CYC(800), .PO_CYC(700), .XFR_CYC(600))
		i_sfps_dev (.CLK(CLK), .RST(RST), .LINK(lnk), .BUSY(busy));
	// Checker defaults equal the device's shortened busy times above
	sfps_assertions
		i_sfps_assertions (.CLK(CLK), .RST(RST), .cs_n(lnk.cs_n),
		.sck(lnk.sck), .si(lnk.si), .so_o(lnk.so_o), .so_oe(lnk.so_oe),
		.rb_o(lnk.rb_o), .rb_oe(lnk.rb_oe), .so(lnk.so), .rdy(lnk.rdy));
	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	// Byte index restarts at each taken request, steps on every take
	always @(posedge CLK) begin
		if (req_valid && req_ready) wr_idx <= 0;
		else if (wr_take) wr_idx <= wr_idx + 1;
	end
	assign wr_data = wbuf[wr_idx % 264];
	// Status answers seen
	always @(posedge CLK) if (rsp_valid) n_rsp <= n_rsp + 1;
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic tick_until(input logic lvl, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (req_ready !== lvl && n < lim);
		if (req_ready !== lvl) begin
			err_count++;
			close_out();
		end
	endtask
	task automatic cmd(input logic [7:0] op, input logic [11:0] pg,
		input logic [8:0] ba, input logic [8:0] len);
		req_op    <= op;
		req_addr  <= {3'h0, pg, ba};
		req_len   <= len;
		req_valid <= 1'b1;
		if (op == OP_STATUS) n_stat++;
		tick_until(1'b0, 3000);
		req_valid <= 1'b0;
		tick_until(1'b1, 20000);
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			cmd(OP_STATUS, 12'h0, 9'h0, 9'h0);
			n++;
		end while (rsp_status[ST_READY_BIT] !== 1'b1 && n < 200);
		`CHK("ready bit", 1'b1, rsp_status[ST_READY_BIT])
		`CHK("busy out", 1'b0, busy)
		if (n >= 200) close_out();
	endtask
	task automatic cmp_page(input logic [7:0] op, input logic [11:0] pg,
		input logic d);
		cmd(op, pg, 9'h0, 9'h0);
		wait_ready();
		`CHK("compare bit", d, rsp_status[ST_COMP_BIT])
	endtask
	initial begin
		RST = 1'b1;
		req_valid = 1'b0;
		req_op = 8'h0;
		req_addr = 24'h0;
		req_len = 9'h0;
		n_stat = 0;
		err_count = 0;
		checked = 0;
		void'($urandom(23788));
		foreach (b1[i]) begin
			b1[i] = 8'($urandom);
			b2[i] = 8'($urandom);
			wbuf[i] = ERASED_BYTE;
		end
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		repeat (3) @(posedge CLK);
		// Erase pages 3 and 5 with an all-ones buffer, load buffer two meanwhile
		cmd(OP_WR_BUF1, 12'h0, 9'h0, 9'd264);
		cmd(OP_EP_BUF1, 12'h3, 9'h0, 9'h0);
		cmd(OP_EP_BUF1, 12'h5, 9'h0, 9'h0);
		wbuf = b2;
		cmd(OP_WR_BUF2, 12'h0, 9'h0, 9'd264);
		wbuf = b1;
		cmd(OP_WR_BUF1, 12'h0, 9'h0, 9'd264);
		cmd(OP_EP_BUF1, 12'h1, 9'h0, 9'h0);
		cmd(OP_STATUS, 12'h0, 9'h0, 9'h1);
		`CHK("busy bit", 1'b0, rsp_status[ST_READY_BIT])
		`CHK("density", DENSITY_CODE, rsp_status[5:3])
		`CHK("busy flag", 1'b1, dev_busy)
		// Stalls in the host until the page op ends
		cmp_page(OP_CMP_BUF1, 12'h1, 1'b0);
		wbuf[0] = ~b1[263];
		wbuf[1] = ~b1[0];
		cmd(OP_WR_BUF1, 12'h0, 9'd263, 9'd2);
		cmp_page(OP_CMP_BUF1, 12'h1, 1'b1);
		wbuf[0] = 8'($urandom);
		wbuf[1] = 8'($urandom);
		cmd(OP_MMP_BUF2, 12'h4, 9'd263, 9'd2);
		wait_ready();
		cmp_page(OP_CMP_BUF2, 12'h4, 1'b0);
		for (int i = 0; i < 5; i++) begin
			cmd(T_OP[i], T_PG[i], 9'h0, 9'h0);
			wait_ready();
			cmp_page(T_CMP[i], T_PG[i], 1'b0);
		end
		@(posedge CLK);
		`CHK("status answers", n_stat, n_rsp)
		close_out();
	end
endmodule
`default_nettype wire
